// ===== verilog/lpms_map.svh
// constants for the low power mode sequencer
`ifndef LPMS_MAP_SVH
`define LPMS_MAP_SVH
`define LPMS_REG_CTRL      4'h0
`define LPMS_REG_STATUS    4'h1
`define LPMS_REG_HOLD      4'h2
`define LPMS_REG_OPTS      4'h3
`define LPMS_CTRL_MODE_LSB 0
`define LPMS_CTRL_MODE_MSB 2
`define LPMS_CTRL_VERY_LOW_POWER_RUN_BIT 3
`define LPMS_CTRL_RST      8'h00
`define LPMS_OPTS_RST      8'h03
`define LPMS_CLK_HZ        25000000
`define LPMS_FLASH_HZ      1000000
`define LPMS_FLASH_DIV     ((`LPMS_CLK_HZ + `LPMS_FLASH_HZ - 1) / `LPMS_FLASH_HZ)
`define LPMS_SETTLE_CYC    4'h3
`define LPMS_RESET_CYC     4'h8
`endif

// ===== verilog/lpms_pkg.sv
// types for the low power mode sequencer
package lpms_pkg;
	typedef enum logic [2:0] {
		LPMS_TGT_STOP   = 3'h0,
		LPMS_TGT_VERY_LOW_POWER_WAIT   = 3'h1,
		LPMS_TGT_VERY_LOW_POWER_STOP   = 3'h2,
		LPMS_TGT_LLS    = 3'h3,
		LPMS_TGT_LVL3   = 3'h4,
		LPMS_TGT_LVL1   = 3'h5,
		LPMS_TGT_LVL0   = 3'h6,
		LPMS_TGT_WAIT   = 3'h7
	} lpms_target_t;
	typedef enum logic [2:0] {
		LPMS_ST_RUN    = 3'h0,
		LPMS_ST_ENTER  = 3'h1,
		LPMS_ST_SLEEP  = 3'h2,
		LPMS_ST_EXIT   = 3'h3,
		LPMS_ST_RESET  = 3'h4
	} lpms_state_t;
endpackage

// ===== verilog/lpms_sequencer.sv
// low power mode sequencer top
//
// Contract
// [R1] very low power run allows only bypassed low power internal or external clock modes.
// [R2] very low power run puts flash in reduced frequency mode, 1 MHz.
// [R3] internal clock mode gives 4 MHz core; bus and flash below 800 kHz. The flash tick stays at 1 MHz in every very low power run clock mode.
// [R4] low voltage detect off and regulator low power during very low power run.
// [R5] very low power wait: core sleeps, fast clock runs, any interrupt returns run.
// [R6] very low power stop: peripheral clocks stop, detect off, converter and pins wake.
// [R7] very low power stop: fast clock off, interrupt controller off, async wakeup wakes.
// [R8] low leakage stop retains state and memory; only wakeup unit wakes, then interrupt. The sequencer also wakes it on enabled nmi and reset pins.
// [R9] software keeps wakeup unit interrupt unmasked or exit from stop stalls.
// [R10] leakage levels 3 and 1 keep oscillator, wakeup, timer, clock, comparator.
// [R11] level 3 keeps upper and lower memory powered.
// [R12] levels 1 and 0 power off both memory arrays.
// [R13] level 0 disables low power oscillator, brown-out optional; few units usable.
// [R14] leakage level recovery runs reset flow and sets wakeup interrupt flag.
// [R15] wait-for-interrupt enters selected mode; interrupt leaves it.
// [R16] leakage stops wake only on wakeup unit, nmi pin or reset pin.
// [R17] pins disabled by flash option byte are ignored as wake sources.
// [R18] leakage level wakeup always passes through reset.
// [R19] after leakage level recovery pins stay held until software releases.
// [R20] normal stop keeps registers and detect on, controller off, async wakeup wakes.
// [R21] on deep sleep read target mode, apply settings, then acknowledge entry.
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "lpms_map.svh"
module lpms_sequencer
	import lpms_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       clk_en,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       core_wfi,
	input  wire logic       core_deep,
	input  wire logic       irq_any,
	input  wire logic       async_wake,
	input  wire logic       wakeup_unit_evt,
	input  wire logic       nmi_pin,
	input  wire logic       reset_pin,
	output logic            sleep_ack,
	output logic            core_clk_en,
	output logic            periph_clk_en,
	output logic            nested_interrupt_controller_en,
	output logic            lvd_en,
	output logic            reg_lowpower,
	output logic            flash_slow,
	output logic            flash_clk_tick,
	output logic            sram_pwr,
	output logic            lpo_en,
	output logic            osc_en,
	output logic            bod_en,
	output logic            io_hold,
	output logic            wake_irq_flag,
	output logic            chip_reset,
	output logic [1:0]      clkgen_mode
);
	logic [7:0]   ctrl_r, ctrl_nxt;
	logic [7:0]   opts_r, opts_nxt;
	lpms_state_t  st_r, st_nxt;
	lpms_target_t tgt_r, tgt_nxt;
	logic [3:0]   cnt_r, cnt_nxt;
	logic [4:0]   fdiv_r, fdiv_nxt;
	logic         hold_r, hold_nxt;
	logic         wflag_r, wflag_nxt;
	logic [7:0]   rdata_r, rdata_nxt;
	logic [15:0]  outs_r, outs_nxt;
	logic         very_low_power_run, leak, deep_stop, wake;
	lpms_target_t sel;

	assign sel  = lpms_target_t'(ctrl_r[`LPMS_CTRL_MODE_MSB:`LPMS_CTRL_MODE_LSB]);
	assign very_low_power_run = ctrl_r[`LPMS_CTRL_VERY_LOW_POWER_RUN_BIT];
	assign leak = (tgt_r == LPMS_TGT_LLS) || (tgt_r == LPMS_TGT_LVL3) ||
	              (tgt_r == LPMS_TGT_LVL1) || (tgt_r == LPMS_TGT_LVL0);

	// wake source selection
	always_comb begin
		deep_stop = 1'b0;
		wake      = 1'b0;
		case (tgt_r)
			LPMS_TGT_WAIT, LPMS_TGT_VERY_LOW_POWER_WAIT: wake = irq_any; // [R5] [R15]
			LPMS_TGT_STOP, LPMS_TGT_VERY_LOW_POWER_STOP: wake = async_wake; // [R7] [R20]
			default: begin
				deep_stop = 1'b1;
				// [R16] [R17]
				wake = wakeup_unit_evt | (nmi_pin & opts_r[0]) | (reset_pin & opts_r[1]);
			end
		endcase
	end

	// sequencer and registers
	always_comb begin
		ctrl_nxt  = ctrl_r;
		opts_nxt  = opts_r;
		st_nxt    = st_r;
		tgt_nxt   = tgt_r;
		cnt_nxt   = cnt_r;
		hold_nxt  = hold_r;
		wflag_nxt = wflag_r;
		rdata_nxt = 8'h00;
		fdiv_nxt  = (fdiv_r == 5'(`LPMS_FLASH_DIV - 1)) ? 5'h00 : fdiv_r + 5'h01;
		if (reg_wr) begin
			case (reg_addr)
				`LPMS_REG_CTRL:   ctrl_nxt = reg_wdata;
				`LPMS_REG_HOLD:   if (reg_wdata[0]) hold_nxt = 1'b0; // [R19]
				`LPMS_REG_STATUS: if (reg_wdata[1]) wflag_nxt = 1'b0;
				`LPMS_REG_OPTS:   opts_nxt = reg_wdata;
				default: ;
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				`LPMS_REG_CTRL:   rdata_nxt = ctrl_r;
				`LPMS_REG_STATUS: rdata_nxt = {3'h0, tgt_r, wflag_r, hold_r} ^ {2'h0, 3'(st_r), 3'h0};
				`LPMS_REG_HOLD:   rdata_nxt = {7'h00, hold_r};
				`LPMS_REG_OPTS:   rdata_nxt = opts_r;
				default:          rdata_nxt = 8'h00;
			endcase
		end
		case (st_r)
			LPMS_ST_RUN: begin
				if (core_wfi) begin // [R15] [R21]
					tgt_nxt = core_deep ? sel : (very_low_power_run ? LPMS_TGT_VERY_LOW_POWER_WAIT : LPMS_TGT_WAIT);
					cnt_nxt = `LPMS_SETTLE_CYC;
					st_nxt  = LPMS_ST_ENTER;
				end
			end
			LPMS_ST_ENTER: begin
				if (cnt_r == 4'h0)
					st_nxt = LPMS_ST_SLEEP; // [R21]
				else
					cnt_nxt = cnt_r - 4'h1;
			end
			LPMS_ST_SLEEP: begin
				if (wake) begin
					if (tgt_r == LPMS_TGT_LVL3 || tgt_r == LPMS_TGT_LVL1 || tgt_r == LPMS_TGT_LVL0) begin
						st_nxt    = LPMS_ST_RESET; // [R18]
						cnt_nxt   = `LPMS_RESET_CYC;
						hold_nxt  = 1'b1; // [R19]
						wflag_nxt = 1'b1; // [R14]
					end else begin
						st_nxt = LPMS_ST_EXIT;
						if (tgt_r == LPMS_TGT_LLS)
							wflag_nxt = 1'b1; // [R8]
					end
				end
			end
			LPMS_ST_RESET: begin
				if (cnt_r == 4'h0)
					st_nxt = LPMS_ST_RUN; // [R14]
				else
					cnt_nxt = cnt_r - 4'h1;
			end
			LPMS_ST_EXIT: st_nxt = LPMS_ST_RUN;
			default: st_nxt = LPMS_ST_RUN;
		endcase
		if (st_r == LPMS_ST_RESET)
			ctrl_nxt = `LPMS_CTRL_RST;
	end

	// per-mode power outputs
	always_comb begin
		logic slp;
		slp = (st_nxt == LPMS_ST_SLEEP);
		// {clkgen[1:0],reset,flag,hold,bod,osc,lpo,sram,ftick,fslow,regl,lvd,nested_interrupt_controller,pclk,cclk}
		outs_nxt = 16'h0000;
		outs_nxt[0]  = !slp && !(st_nxt == LPMS_ST_RESET);
		outs_nxt[1]  = !slp || (tgt_nxt == LPMS_TGT_WAIT) || (tgt_nxt == LPMS_TGT_VERY_LOW_POWER_WAIT); // [R6] [R8]
		outs_nxt[2]  = !slp || !deep_stop && (tgt_nxt != LPMS_TGT_STOP) && (tgt_nxt != LPMS_TGT_VERY_LOW_POWER_STOP) ||
		               (tgt_nxt == LPMS_TGT_VERY_LOW_POWER_WAIT) || (tgt_nxt == LPMS_TGT_WAIT); // [R5] [R7]
		outs_nxt[3]  = very_low_power_run ? 1'b0 : (!slp || tgt_nxt == LPMS_TGT_STOP || tgt_nxt == LPMS_TGT_WAIT); // [R4] [R20]
		outs_nxt[4]  = very_low_power_run || (slp && tgt_nxt != LPMS_TGT_STOP && tgt_nxt != LPMS_TGT_WAIT); // [R4]
		outs_nxt[5]  = very_low_power_run; // [R2]
		outs_nxt[6]  = very_low_power_run && (fdiv_r == 5'h00); // [R2] [R3]
		outs_nxt[7]  = !(slp && (tgt_nxt == LPMS_TGT_LVL1 || tgt_nxt == LPMS_TGT_LVL0)); // [R11] [R12]
		outs_nxt[8]  = !(slp && tgt_nxt == LPMS_TGT_LVL0); // [R13]
		outs_nxt[9]  = !(slp && tgt_nxt == LPMS_TGT_LVL0); // [R10] [R13]
		outs_nxt[10] = !(slp && tgt_nxt == LPMS_TGT_LVL0) || opts_r[2]; // [R13]
		outs_nxt[11] = hold_nxt; // [R19]
		outs_nxt[12] = wflag_nxt;
		outs_nxt[13] = (st_nxt == LPMS_ST_RESET);
		outs_nxt[15:14] = very_low_power_run ? {1'b1, ctrl_r[4]} : 2'b00; // [R1]
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ctrl_r  <= `LPMS_CTRL_RST;
			opts_r  <= `LPMS_OPTS_RST;
			st_r    <= LPMS_ST_RUN;
			tgt_r   <= LPMS_TGT_STOP;
			cnt_r   <= 4'h0;
			fdiv_r  <= 5'h00;
			hold_r  <= 1'b0;
			wflag_r <= 1'b0;
			rdata_r <= 8'h00;
			outs_r  <= 16'h078f;
		end else if (clk_en) begin
			ctrl_r  <= ctrl_nxt;
			opts_r  <= opts_nxt;
			st_r    <= st_nxt;
			tgt_r   <= tgt_nxt;
			cnt_r   <= cnt_nxt;
			fdiv_r  <= fdiv_nxt;
			hold_r  <= hold_nxt;
			wflag_r <= wflag_nxt;
			rdata_r <= rdata_nxt;
			outs_r  <= outs_nxt;
		end
	end

	logic ack_r;
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			ack_r <= 1'b0;
		else if (clk_en)
			ack_r <= (st_nxt == LPMS_ST_SLEEP); // [R21]
	end

	assign reg_rdata      = rdata_r;
	assign sleep_ack      = ack_r;
	assign core_clk_en    = outs_r[0];
	assign periph_clk_en  = outs_r[1];
	assign nested_interrupt_controller_en        = outs_r[2];
	assign lvd_en         = outs_r[3];
	assign reg_lowpower   = outs_r[4];
	assign flash_slow     = outs_r[5];
	assign flash_clk_tick = outs_r[6];
	assign sram_pwr       = outs_r[7];
	assign lpo_en         = outs_r[8];
	assign osc_en         = outs_r[9];
	assign bod_en         = outs_r[10];
	assign io_hold        = outs_r[11];
	assign wake_irq_flag  = outs_r[12];
	assign chip_reset     = outs_r[13];
	assign clkgen_mode    = outs_r[15:14];

	a_entry_ack: assert property (@(posedge sys_clk) disable iff (!rstn) // [R21]
		clk_en && st_r == LPMS_ST_RUN && core_wfi ##1 clk_en[*4] |=> sleep_ack)
		else $error("entry not acknowledged after settle");
	a_very_low_power_run_lvd: assert property (@(posedge sys_clk) disable iff (!rstn) // [R4]
		$past(very_low_power_run) && $past(clk_en) |-> !lvd_en && reg_lowpower)
		else $error("detect on in very low power run");
	a_very_low_power_run_clk: assert property (@(posedge sys_clk) disable iff (!rstn) // [R1]
		$past(very_low_power_run) && $past(clk_en) |-> clkgen_mode[1])
		else $error("bad clock mode in very low power run");
	a_lvl_mem: assert property (@(posedge sys_clk) disable iff (!rstn) // [R12]
		st_r == LPMS_ST_SLEEP && (tgt_r == LPMS_TGT_LVL1 || tgt_r == LPMS_TGT_LVL0) |-> !sram_pwr)
		else $error("memory powered in level 1 or 0");
	a_lvl3_mem: assert property (@(posedge sys_clk) disable iff (!rstn) // [R11]
		st_r == LPMS_ST_SLEEP && tgt_r == LPMS_TGT_LVL3 |-> sram_pwr)
		else $error("memory lost in level 3");
	a_lvl_reset: assert property (@(posedge sys_clk) disable iff (!rstn) // [R18]
		clk_en && st_r == LPMS_ST_SLEEP && wake && tgt_r inside {LPMS_TGT_LVL3, LPMS_TGT_LVL1, LPMS_TGT_LVL0}
		|=> chip_reset && io_hold && wake_irq_flag)
		else $error("leakage wake skipped reset");
	a_lvl0_lpo: assert property (@(posedge sys_clk) disable iff (!rstn) // [R13]
		st_r == LPMS_ST_SLEEP && tgt_r == LPMS_TGT_LVL0 |-> !lpo_en && !osc_en)
		else $error("oscillator on in level 0");
	a_stop_nested_interrupt_controller: assert property (@(posedge sys_clk) disable iff (!rstn) // [R7]
		st_r == LPMS_ST_SLEEP && tgt_r == LPMS_TGT_VERY_LOW_POWER_STOP |-> !nested_interrupt_controller_en && !core_clk_en && !periph_clk_en)
		else $error("controller on in very low power stop");
	a_pin_ignored: assert property (@(posedge sys_clk) disable iff (!rstn) // [R17]
		clk_en && st_r == LPMS_ST_SLEEP && leak && !wakeup_unit_evt && !(nmi_pin && opts_r[0])
		&& !(reset_pin && opts_r[1]) |=> st_r == LPMS_ST_SLEEP)
		else $error("disabled pin woke chip");
	a_very_low_power_run_flash: assert property (@(posedge sys_clk) disable iff (!rstn) // [R2]
		$past(very_low_power_run) && $past(clk_en) |-> flash_slow)
		else $error("flash fast in very low power run");
	a_very_low_power_wait_nested_interrupt_controller: assert property (@(posedge sys_clk) disable iff (!rstn) // [R5]
		st_r == LPMS_ST_SLEEP && tgt_r == LPMS_TGT_VERY_LOW_POWER_WAIT |-> nested_interrupt_controller_en && periph_clk_en && !core_clk_en)
		else $error("controller off in very low power wait");
	a_very_low_power_stop_lvd: assert property (@(posedge sys_clk) disable iff (!rstn) // [R6]
		st_r == LPMS_ST_SLEEP && tgt_r == LPMS_TGT_VERY_LOW_POWER_STOP |-> !lvd_en && reg_lowpower)
		else $error("detect on in very low power stop");
	a_lls_keep: assert property (@(posedge sys_clk) disable iff (!rstn) // [R8]
		st_r == LPMS_ST_SLEEP && tgt_r == LPMS_TGT_LLS |-> sram_pwr && !periph_clk_en && !nested_interrupt_controller_en)
		else $error("low leakage stop state wrong");
	a_lvl_osc: assert property (@(posedge sys_clk) disable iff (!rstn) // [R10]
		st_r == LPMS_ST_SLEEP && tgt_r inside {LPMS_TGT_LVL3, LPMS_TGT_LVL1} |-> osc_en && lpo_en)
		else $error("oscillator off in level 3 or 1");
	a_stop_lvd: assert property (@(posedge sys_clk) disable iff (!rstn) // [R20]
		st_r == LPMS_ST_SLEEP && tgt_r == LPMS_TGT_STOP && !$past(very_low_power_run)
		|-> lvd_en && !nested_interrupt_controller_en && !periph_clk_en)
		else $error("normal stop state wrong");
	a_reset_ctrl: assert property (@(posedge sys_clk) disable iff (!rstn) // [R14]
		clk_en && st_r == LPMS_ST_RESET |=> ctrl_r == `LPMS_CTRL_RST)
		else $error("control kept through reset flow");
	a_wait_wake: assert property (@(posedge sys_clk) disable iff (!rstn) // [R15]
		clk_en && st_r == LPMS_ST_SLEEP && tgt_r inside {LPMS_TGT_WAIT, LPMS_TGT_VERY_LOW_POWER_WAIT} && irq_any
		|=> !sleep_ack && core_clk_en)
		else $error("interrupt did not end wait");
	a_lls_exit: assert property (@(posedge sys_clk) disable iff (!rstn) // [R16]
		clk_en && st_r == LPMS_ST_SLEEP && tgt_r == LPMS_TGT_LLS && wakeup_unit_evt
		|=> st_r == LPMS_ST_EXIT && wake_irq_flag)
		else $error("wakeup unit did not end low leakage stop");
	a_hold_keep: assert property (@(posedge sys_clk) disable iff (!rstn) // [R19]
		io_hold && !(clk_en && reg_wr && reg_addr == `LPMS_REG_HOLD && reg_wdata[0]) |=> io_hold)
		else $error("pin hold dropped without release");
	a_freeze_state: assert property (@(posedge sys_clk) disable iff (!rstn)
		!clk_en |=> $stable(st_r) && $stable(ctrl_r) && $stable(outs_r))
		else $error("state moved while clock enable low");
	c_wait_wake: cover property (@(posedge sys_clk) st_r == LPMS_ST_SLEEP && tgt_r == LPMS_TGT_WAIT ##1 st_r == LPMS_ST_EXIT);
	c_lls_wake: cover property (@(posedge sys_clk) st_r == LPMS_ST_SLEEP && tgt_r == LPMS_TGT_LLS ##1 st_r == LPMS_ST_EXIT);
	c_lvl_reset: cover property (@(posedge sys_clk) st_r == LPMS_ST_RESET);
	c_very_low_power_wait_wake: cover property (@(posedge sys_clk)
		st_r == LPMS_ST_SLEEP && tgt_r == LPMS_TGT_VERY_LOW_POWER_WAIT ##1 st_r == LPMS_ST_EXIT);
	c_lvl0_sleep: cover property (@(posedge sys_clk)
		st_r == LPMS_ST_SLEEP && tgt_r == LPMS_TGT_LVL0 && !sram_pwr);
endmodule

// ===== sim/lpms_core_model.sv
// core and wake source model for the low power mode sequencer
`timescale 1ns/1ps
module lpms_core_model (
	input  wire logic sys_clk,
	output logic      core_wfi,
	output logic      core_deep,
	output logic      irq_any,
	output logic      async_wake,
	output logic      wakeup_unit_evt,
	output logic      nmi_pin,
	output logic      reset_pin
);
	initial begin
		{core_wfi, core_deep, irq_any, async_wake, wakeup_unit_evt, nmi_pin, reset_pin} = 7'h00;
	end
	// one-cycle wait-for-interrupt pulse with the deep flag beside it
	task automatic sleep(input logic deep);
		@(posedge sys_clk);
		core_wfi <= 1'b1;
		core_deep <= deep;
		@(posedge sys_clk);
		core_wfi <= 1'b0;
	endtask
	// wake lines by index: 0 irq, 1 async, 2 wakeup unit, 3 nmi, 4 reset pin; released lines go low
	// wakeup unit interrupt is never masked, so its service always completes the exit
	task automatic wake(input int src, input logic on);
		@(posedge sys_clk);
		{reset_pin, nmi_pin, wakeup_unit_evt, async_wake, irq_any} <= on ? 5'h01 << src : 5'h00;
	endtask
endmodule

// ===== sim/lpms_sequencer_bench.sv
// self-checking bench for the low power mode sequencer
`timescale 1ns/1ps
module lpms_sequencer_bench
	import lpms_pkg::*;
;
	logic       sys_clk, rstn, clk_en, reg_wr, reg_rd, sleep_ack, core_clk_en, periph_clk_en, nested_interrupt_controller_en, lvd_en;
	logic       core_wfi, core_deep, irq_any, async_wake, wakeup_unit_evt, nmi_pin, reset_pin, reg_lowpower;
	logic       flash_slow, flash_clk_tick, sram_pwr, lpo_en, osc_en, bod_en, io_hold, wake_irq_flag, chip_reset;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata;
	logic [1:0] clkgen_mode;
	int         err_count, n_checks, cyc;
	lpms_sequencer uut (.sys_clk, .rstn, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_wfi,
		.core_deep, .irq_any, .async_wake, .wakeup_unit_evt, .nmi_pin, .reset_pin, .sleep_ack, .core_clk_en,
		.periph_clk_en, .nested_interrupt_controller_en, .lvd_en, .reg_lowpower, .flash_slow, .flash_clk_tick, .sram_pwr, .lpo_en,
		.osc_en, .bod_en, .io_hold, .wake_irq_flag, .chip_reset, .clkgen_mode);
	lpms_core_model core_m (.sys_clk, .core_wfi, .core_deep, .irq_any, .async_wake, .wakeup_unit_evt, .nmi_pin,
		.reset_pin);
	initial begin
		sys_clk = 1'b0;
	end
	always #20 sys_clk = ~sys_clk;
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdchk(input string what, input logic [3:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(what, 16'(exp), 16'(reg_rdata));
	endtask
	task automatic settle;
		repeat (3) @(posedge sys_clk);
		#1;
	endtask
	// bundle order: core, periph, nested_interrupt_controller, lvd, regulator low power, sram, lpo, osc, brown-out
	task automatic pw(input string m, input logic [8:0] mask, input logic [8:0] exp);
		chk(m, 16'(exp & mask), 16'({core_clk_en, periph_clk_en, nested_interrupt_controller_en, lvd_en, reg_lowpower, sram_pwr,
			lpo_en, osc_en, bod_en} & mask));
	endtask
	task automatic wait_on(input logic chip, input logic v);
		for (int i = 0; i < 40; i++) begin
			@(posedge sys_clk);
			#1;
			if ((chip ? chip_reset : sleep_ack) === v) return;
		end
		chk(chip ? "chip_reset wait" : "sleep_ack wait", 16'(v), 16'(!v));
	endtask
	task automatic nap(input logic deep, input string m, input logic [8:0] mask, input logic [8:0] exp);
		core_m.sleep(deep);
		wait_on(1'b0, 1'b1);
		pw(m, mask, exp);
	endtask
	task automatic rouse(input int src);
		core_m.wake(src, 1'b1);
		wait_on(1'b0, 1'b0);
		core_m.wake(0, 1'b0);
	endtask
	task automatic t_very_low_power_run;
		int n;
		rdchk("opts reset", 4'h3, 8'h03);
		rdchk("unmapped", 4'hf, 8'h00);
		wr(4'h0, 8'h08);
		settle();
		pw("very_low_power_run power", 9'h17f, 9'h15f);
		chk("flash slow", 16'h1, 16'(flash_slow));
		chk("clk internal", 16'h2, 16'(clkgen_mode));
		wr(4'h0, 8'h18);
		settle();
		chk("clk external", 16'h3, 16'(clkgen_mode));
		for (n = 0; n < 60 && flash_clk_tick !== 1'b1; n++) @(posedge sys_clk) #1;
		n = 0;
		do begin
			@(posedge sys_clk) #1;
			n++;
		end while (flash_clk_tick !== 1'b1 && n < 60);
		chk("tick period", 16'h0019, 16'(n));
		$display("very_low_power_run test done");
	endtask
	task automatic t_waits;
		nap(1'b0, "very_low_power_wait power", 9'h07d, 9'h05d);
		rouse(0);
		wr(4'h0, {4'h0, 1'b1, LPMS_TGT_VERY_LOW_POWER_STOP});
		nap(1'b1, "very_low_power_stop power", 9'h1f9, 9'h019);
		rouse(1);
		wr(4'h0, {5'h00, LPMS_TGT_STOP});
		nap(1'b1, "stop power", 9'h1e9, 9'h029);
		rouse(1);
		nap(1'b0, "wait power", 9'h1ff, 9'h0ef);
		rouse(0);
		$display("wait and stop test done");
	endtask
	// a write while the clock enable is low must not land
	task automatic t_freeze;
		@(posedge sys_clk);
		clk_en <= 1'b0;
		wr(4'h3, 8'h00);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		rdchk("opts frozen", 4'h3, 8'h03);
		$display("freeze test done");
	endtask
	task automatic t_lls(input logic [7:0] opts);
		wr(4'h3, opts);
		wr(4'h0, {5'h00, LPMS_TGT_LLS});
		nap(1'b1, "lls power", 9'h0c8, 9'h008);
		for (int s = 0; s < 5; s++) begin
			if (s != 2 && !(s == 3 && opts[0]) && !(s == 4 && opts[1])) core_m.wake(s, 1'b1);
			repeat (6) @(posedge sys_clk);
			#1 chk("lls held", 16'h1, 16'(sleep_ack));
			core_m.wake(0, 1'b0);
		end
		rouse(2);
		chk("lls flag", 16'h1, 16'(wake_irq_flag));
		wr(4'h1, 8'h02);
		settle();
		chk("flag clear", 16'h0, 16'(wake_irq_flag));
		wr(4'h3, 8'h03);
		$display("lls test done");
	endtask
	task automatic t_level(input lpms_target_t t, input logic [8:0] exp, input int src);
		wr(4'h0, {5'h00, t});
		nap(1'b1, "level power", 9'h04f, exp);
		core_m.wake(src, 1'b1);
		wait_on(1'b1, 1'b1);
		core_m.wake(0, 1'b0);
		wait_on(1'b1, 1'b0);
		wait_on(1'b0, 1'b0);
		chk("level flag", 16'h1, 16'(wake_irq_flag));
		rdchk("ctrl after reset", 4'h0, 8'h00);
		rdchk("hold read", 4'h2, 8'h01);
		wr(4'h2, 8'h01);
		settle();
		chk("hold released", 16'h0, 16'(io_hold));
		wr(4'h1, 8'h02);
		$display("level test done");
	endtask
	initial begin
		{rstn, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		clk_en = 1'b1;
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		t_very_low_power_run();
		t_waits();
		t_freeze();
		t_lls(8'h03);
		t_lls(8'h00);
		t_level(LPMS_TGT_LVL3, 9'h00f, 2);
		t_level(LPMS_TGT_LVL1, 9'h007, 4);
		t_level(LPMS_TGT_LVL0, 9'h000, 3);
		finish_test();
	end
endmodule
